/* inc/accr_pkg.sv */
// Constants, field layouts and carrier types for the channel calibration
// and configuration register bank.
// Assumes a 32-bit AHB-Lite slave where each register takes one word.
package accr_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam int IDX_W = 6;
    localparam logic [5:0] IDX_GLOBAL_DC = 6'h08;
    localparam logic [5:0] IDX_C0_OFS_HI = 6'h0a;
    localparam logic [5:0] IDX_C0_OFS_LO = 6'h0b;
    localparam logic [5:0] IDX_C0_GAIN_HI = 6'h0c;
    localparam logic [5:0] IDX_C0_GAIN_LO = 6'h0d;
    localparam logic [5:0] IDX_C1_CFG = 6'h0e;
    localparam logic [5:0] IDX_C1_OFS_HI = 6'h0f;
    localparam logic [5:0] IDX_C1_OFS_LO = 6'h10;

    // ------------------------------------------------------------------
    // Calibration pairs: slot numbers and their word indices
    // ------------------------------------------------------------------
    localparam int NUM_CAL = 3;
    localparam int CAL_C0_OFS = 0;
    localparam int CAL_C0_GAIN = 1;
    localparam int CAL_C1_OFS = 2;
    localparam logic [5:0] CAL_HI_IDX [NUM_CAL] =
        '{IDX_C0_OFS_HI, IDX_C0_GAIN_HI, IDX_C1_OFS_HI};
    localparam logic [5:0] CAL_LO_IDX [NUM_CAL] =
        '{IDX_C0_OFS_LO, IDX_C0_GAIN_LO, IDX_C1_OFS_LO};
    localparam logic [15:0] CAL_HI_RST [NUM_CAL] =
        '{16'h0000, 16'h8000, 16'h0000};

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int LO_BYTE_LSB = 8;
    localparam int DELAY_LSB = 6;
    localparam int DELAY_MSB = 15;
    localparam int DC_OFF_BIT = 2;
    localparam int INSEL_MSB = 1;
    localparam int GLOBAL_DC_MSB = 3;
    localparam logic [7:0] LO_BYTE_RST = 8'h00;
    localparam logic [15:0] CFG_RST = 16'h0000;
    localparam logic [3:0] GLOBAL_DC_RST = 4'h0;

    // ------------------------------------------------------------------
    // Bus encodings
    // ------------------------------------------------------------------
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [15:0] RD_ZERO = 16'h0000;

    // Input routing codes of channel 1
    typedef enum logic [1:0] {
        INSEL_PINS = 2'h0,
        INSEL_SHORT = 2'h1,
        INSEL_POS_TEST = 2'h2,
        INSEL_NEG_TEST = 2'h3
    } accr_insel_t;

    // One register write, as delivered by the bus slave
    typedef struct packed {
        logic wr;
        logic [5:0] idx;
        logic [15:0] data;
    } accr_wreq_t;

    // Channel 1 configuration fields
    typedef struct packed {
        logic [9:0] delay;
        logic dc_off;
        accr_insel_t insel;
    } accr_cfg_t;

    // One-hot routing of channel 1's converter input
    typedef struct packed {
        logic pins;
        logic shorted;
        logic pos_test;
        logic neg_test;
    } accr_route_t;

endpackage : accr_pkg

/* design/accr_ahb_slave.sv */
// AHB-Lite front end: zero-wait writes, one wait state on reads.
// Assumes a single master and that hready is this slave's hreadyout.
`timescale 1ns/100ps
module accr_ahb_slave (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave side
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Register file side
    output accr_pkg::accr_wreq_t wreq,
    output logic [5:0] rd_idx,
    input wire logic [15:0] rd_data
);

    // ------------------------------------------------------------------
    // Address phase capture
    // ------------------------------------------------------------------
    logic dp_valid;
    logic dp_write;
    logic dp_ok;
    logic [5:0] dp_idx;
    logic rd_done;

    // Only aligned word transfers inside the first 256 bytes act
    wire logic addr_take = hsel & hready & htrans[1];
    wire logic addr_ok = (hsize == accr_pkg::HSIZE_WORD) &
                         (haddr[1:0] == 2'h0) & (haddr[31:8] == 24'h0);
    wire logic dp_read = dp_valid & ~dp_write;
    wire logic next_rd_done = dp_read & ~rd_done;

    // Phase registers move only when the bus advances
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_ok <= 1'b0;
            dp_idx <= 6'h00;
        end else if (hready) begin
            dp_valid <= addr_take;
            dp_write <= hwrite;
            dp_ok <= addr_ok;
            dp_idx <= haddr[7:2];
        end
    end

    // Read data is taken a cycle late so a just-written value is seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_done <= 1'b0;
            hrdata <= 32'h0000_0000;
        end else begin
            rd_done <= next_rd_done;
            if (next_rd_done) begin
                hrdata <= {16'h0000, dp_ok ? rd_data : accr_pkg::RD_ZERO};
            end
        end
    end

    // Handshake and register-side strobes
    assign hreadyout = ~next_rd_done;
    assign hresp = 1'b0;
    assign rd_idx = dp_idx;
    assign wreq.wr = dp_valid & dp_write & dp_ok;
    assign wreq.idx = dp_idx;
    assign wreq.data = hwdata[15:0];

endmodule : accr_ahb_slave

/* design/accr_chan_route.sv */
// Channel 1 routing: input select decode and DC-block steering.
// Assumes its configuration inputs come straight from flip-flops.
`timescale 1ns/100ps
module accr_chan_route (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Configuration
    input wire accr_pkg::accr_cfg_t cfg,
    input wire logic [3:0] global_dc_reject_setting,
    // Steering to the converter channel
    output accr_pkg::accr_route_t route,
    output logic chan1_dc_bypass,
    output logic [3:0] chan1_dc_setting
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    accr_pkg::accr_route_t next_route;

    // One-hot input routing from the two-bit select
    always_comb begin
        next_route = '0;
        case (cfg.insel)
            accr_pkg::INSEL_PINS: next_route.pins = 1'b1;
            accr_pkg::INSEL_SHORT: next_route.shorted = 1'b1;
            accr_pkg::INSEL_POS_TEST: next_route.pos_test = 1'b1;
            accr_pkg::INSEL_NEG_TEST: next_route.neg_test = 1'b1;
            default: next_route.pins = 1'b1;
        endcase
    end

    // Registered so the analog switches see no decode glitches
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            route <= '{pins: 1'b1, default: 1'b0};
            chan1_dc_bypass <= 1'b0;
            chan1_dc_setting <= accr_pkg::GLOBAL_DC_RST;
        end else begin
            route <= next_route;
            chan1_dc_bypass <= cfg.dc_off;
            chan1_dc_setting <= global_dc_reject_setting;
        end
    end

endmodule : accr_chan_route

/* design/accr_regs.sv */
// Top of the channel calibration and configuration register bank.
// Assumes one 40 MHz clock, an AHB-Lite master, and that the converter
// channels consume the applied calibration and steering outputs.
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/100ps

// What this block does
// - Channel 0 offset bits 23:8 sit in offset high word bits 15:0.
// - Channel 0 offset bits 7:0 sit in low word 15:8; 7:0 read zero.
// - Gain words form an unsigned 24-bit gain from 0 to below 2.0.
// - Channel 0 gain high resets to 8000h, gain low to zero.
// - Channel 0 gain bits 7:0 sit in low word 15:8; 7:0 read zero.
// - Channel 1 signed 10-bit delay in config 15:6; 5:3 read zero.
// - Config bit 2 clear follows global DC-block; set bypasses it.
// - Config bits 1:0 pick pins, shorted, positive or negative test.
// - Channel 1 offset splits like channel 0: high word, low 15:8.
// - Channel 1 config and offset words reset to all zeros.
// - Global DC-block setting is bits 3:0 of threshold low word.
module accr_regs (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Applied calibration values
    output logic [23:0] chan0_offset,
    output logic [23:0] chan0_gain,
    output logic [23:0] chan1_offset,
    // Channel 1 steering
    output logic [9:0] chan1_delay_cycles,
    output accr_pkg::accr_route_t chan1_route,
    output logic chan1_dc_bypass,
    output logic [3:0] chan1_dc_setting
);

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    accr_pkg::accr_wreq_t wreq;
    logic [5:0] rd_idx;
    logic [15:0] rd_data;

    accr_ahb_slave u_slave (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .wreq(wreq),
        .rd_idx(rd_idx),
        .rd_data(rd_data)
    );

    // ------------------------------------------------------------------
    // Calibration pairs
    // ------------------------------------------------------------------
    logic [15:0] cal_hi [accr_pkg::NUM_CAL];
    logic [7:0] cal_lo [accr_pkg::NUM_CAL];
    logic [23:0] cal_applied [accr_pkg::NUM_CAL];
    logic [accr_pkg::NUM_CAL-1:0] hit_hi;
    logic [accr_pkg::NUM_CAL-1:0] hit_lo;
    logic [accr_pkg::NUM_CAL-1:0] rd_hi;
    logic [accr_pkg::NUM_CAL-1:0] rd_lo;

    // Each pair: high word stages, low word write commits both together,
    // so the datapath never sees a half-updated correction
    for (genvar i = 0; i < accr_pkg::NUM_CAL; i++) begin : g_cal
        assign hit_hi[i] = wreq.wr & (wreq.idx == accr_pkg::CAL_HI_IDX[i]);
        assign hit_lo[i] = wreq.wr & (wreq.idx == accr_pkg::CAL_LO_IDX[i]);
        assign rd_hi[i] = (rd_idx == accr_pkg::CAL_HI_IDX[i]);
        assign rd_lo[i] = (rd_idx == accr_pkg::CAL_LO_IDX[i]);

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                cal_hi[i] <= accr_pkg::CAL_HI_RST[i];
                cal_lo[i] <= accr_pkg::LO_BYTE_RST;
                cal_applied[i] <= {accr_pkg::CAL_HI_RST[i],
                                   accr_pkg::LO_BYTE_RST};
            end else begin
                if (hit_hi[i]) begin
                    cal_hi[i] <= wreq.data;
                end
                if (hit_lo[i]) begin
                    cal_lo[i] <= wreq.data[15:8];
                    cal_applied[i] <= {cal_hi[i], wreq.data[15:8]};
                end
            end
        end
    end

    // Gain stays unsigned: 800000h is unity, top code just under 2.0
    assign chan0_offset = cal_applied[accr_pkg::CAL_C0_OFS];
    assign chan0_gain = cal_applied[accr_pkg::CAL_C0_GAIN];
    assign chan1_offset = cal_applied[accr_pkg::CAL_C1_OFS];

    // ------------------------------------------------------------------
    // Channel 1 configuration and global DC-block setting
    // ------------------------------------------------------------------
    accr_pkg::accr_cfg_t cfg;
    logic [3:0] global_dc_reject_setting;

    wire logic hit_cfg = wreq.wr & (wreq.idx == accr_pkg::IDX_C1_CFG);
    wire logic hit_gdc = wreq.wr & (wreq.idx == accr_pkg::IDX_GLOBAL_DC);
    wire accr_pkg::accr_cfg_t next_cfg = '{
        delay: wreq.data[accr_pkg::DELAY_MSB:accr_pkg::DELAY_LSB],
        dc_off: wreq.data[accr_pkg::DC_OFF_BIT],
        insel: accr_pkg::accr_insel_t'(wreq.data[accr_pkg::INSEL_MSB:0])
    };

    // Reserved bits 5:3 are simply not stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg <= accr_pkg::accr_cfg_t'(13'h0000);
            global_dc_reject_setting <= accr_pkg::GLOBAL_DC_RST;
        end else begin
            if (hit_cfg) begin
                cfg <= next_cfg;
            end
            if (hit_gdc) begin
                global_dc_reject_setting <=
                    wreq.data[accr_pkg::GLOBAL_DC_MSB:0];
            end
        end
    end

    // Delay is two's complement; consumer sign-extends as needed
    assign chan1_delay_cycles = cfg.delay;

    accr_chan_route u_route (
        .hclk(hclk),
        .hresetn(hresetn),
        .cfg(cfg),
        .global_dc_reject_setting(global_dc_reject_setting),
        .route(chan1_route),
        .chan1_dc_bypass(chan1_dc_bypass),
        .chan1_dc_setting(chan1_dc_setting)
    );

    // ------------------------------------------------------------------
    // Read-back
    // ------------------------------------------------------------------
    // Reserved bits and unmapped indices read zero
    always_comb begin
        rd_data = accr_pkg::RD_ZERO;
        for (int i = 0; i < accr_pkg::NUM_CAL; i++) begin
            if (rd_hi[i]) begin
                rd_data = cal_hi[i];
            end
            if (rd_lo[i]) begin
                rd_data = {cal_lo[i], 8'h00};
            end
        end
        if (rd_idx == accr_pkg::IDX_C1_CFG) begin
            rd_data = {cfg.delay, 3'h0, cfg.dc_off, cfg.insel};
        end
        if (rd_idx == accr_pkg::IDX_GLOBAL_DC) begin
            rd_data = {12'h000, global_dc_reject_setting};
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // High for the first clocked cycle after reset release
    logic first_cycle;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            first_cycle <= 1'b1;
        end else begin
            first_cycle <= 1'b0;
        end
    end

    a_reset_gain_unity: assert property (
        first_cycle |-> (chan0_gain == 24'h800000) &&
                        (cal_hi[accr_pkg::CAL_C0_GAIN] == 16'h8000))
        else $error("Channel 0 gain not unity after reset");

    a_reset_chan1_zero: assert property (
        first_cycle |-> (chan1_offset == 24'h000000) &&
                        (chan1_delay_cycles == 10'h000) &&
                        !cfg.dc_off && (cfg.insel == accr_pkg::INSEL_PINS))
        else $error("Channel 1 words not zero after reset");

    a_c0_offset_commit: assert property (
        hit_lo[accr_pkg::CAL_C0_OFS] |=>
            chan0_offset == {$past(cal_hi[accr_pkg::CAL_C0_OFS]),
                             $past(wreq.data[15:8])})
        else $error("Channel 0 offset pair not applied");

    a_c0_low_byte: assert property (
        hit_lo[accr_pkg::CAL_C0_OFS] ##1 (rd_idx == accr_pkg::IDX_C0_OFS_LO)
            |-> rd_data == {$past(wreq.data[15:8]), 8'h00})
        else $error("Channel 0 offset low word read-back wrong");

    a_gain_commit: assert property (
        hit_lo[accr_pkg::CAL_C0_GAIN] |=>
            chan0_gain[7:0] == $past(wreq.data[15:8]))
        else $error("Channel 0 gain low byte not applied");

    a_gain_unsigned_top: assert property (
        $rose(hit_lo[accr_pkg::CAL_C0_GAIN]) &&
            (cal_hi[accr_pkg::CAL_C0_GAIN] == 16'hffff) &&
            (wreq.data[15:8] == 8'hff) |=> chan0_gain == 24'hffffff)
        else $error("Full-scale gain code altered");

    a_c1_offset_pair: assert property (
        hit_lo[accr_pkg::CAL_C1_OFS] |=>
            chan1_offset[23:8] == $past(cal_hi[accr_pkg::CAL_C1_OFS]))
        else $error("Channel 1 offset high word not paired");

    a_hi_only_staged: assert property (
        hit_hi[accr_pkg::CAL_C1_OFS] && !hit_lo[accr_pkg::CAL_C1_OFS]
            |=> $stable(chan1_offset))
        else $error("High word write changed applied offset");

    a_delay_field: assert property (
        hit_cfg |=> chan1_delay_cycles == $past(wreq.data[15:6]) ##0
            ((rd_idx != accr_pkg::IDX_C1_CFG) || (rd_data[5:3] == 3'h0)))
        else $error("Delay field or reserved bits wrong");

    a_dc_steer: assert property (
        hit_cfg ##1 !hit_cfg |=> chan1_dc_bypass == $past(wreq.data[2], 2))
        else $error("DC-block bypass does not follow config bit");

    a_global_dc: assert property (
        hit_gdc ##1 !hit_gdc |=> chan1_dc_setting == $past(wreq.data[3:0], 2))
        else $error("Global DC-block setting not forwarded");

    a_route_select: assert property (
        (cfg.insel == accr_pkg::INSEL_NEG_TEST) [*2] |->
            chan1_route.neg_test && !chan1_route.pins)
        else $error("Negative test routing missing");

    a_route_onehot: assert property (
        $onehot(chan1_route))
        else $error("Route not one-hot");

    a_unmapped_zero: assert property (
        rd_idx > accr_pkg::IDX_C1_OFS_LO
            |-> rd_data == 16'h0000)
        else $error("Unmapped read not zero");

    a_lo_reserved: assert property (
        (|rd_lo)
            |-> rd_data[7:0] == 8'h00)
        else $error("Low reserved bits set");

    a_cfg_reserved: assert property (
        rd_idx == accr_pkg::IDX_C1_CFG
            |-> rd_data[5:3] == 3'h0)
        else $error("Config reserved bits set");

    a_gdc_reserved: assert property (
        rd_idx == accr_pkg::IDX_GLOBAL_DC
            |-> rd_data[15:4] == 12'h000)
        else $error("DC upper bits set");

    a_c1_low_commit: assert property (
        hit_lo[accr_pkg::CAL_C1_OFS]
            |=> chan1_offset[7:0] == $past(wreq.data[15:8]))
        else $error("Ch1 low byte not applied");

    a_gain_staged: assert property (
        hit_hi[accr_pkg::CAL_C0_GAIN]
            |=> $stable(chan0_gain))
        else $error("Gain moved on high write");

    a_ofs_staged: assert property (
        hit_hi[accr_pkg::CAL_C0_OFS]
            |=> $stable(chan0_offset))
        else $error("Offset moved on high write");

    a_hi_readback: assert property (
        hit_hi[accr_pkg::CAL_C0_OFS] ##1 (rd_idx == accr_pkg::IDX_C0_OFS_HI)
            |-> rd_data == $past(wreq.data))
        else $error("High word not read back");

    a_gain_lo_back: assert property (
        hit_lo[accr_pkg::CAL_C0_GAIN] ##1
            (rd_idx == accr_pkg::IDX_C0_GAIN_LO)
            |-> rd_data[15:8] == $past(wreq.data[15:8]))
        else $error("Gain low not read back");

    c_gain_written: cover property (hit_hi[accr_pkg::CAL_C0_GAIN] ##[1:20]
                                    hit_lo[accr_pkg::CAL_C0_GAIN]);
    c_dc_bypassed: cover property ($rose(chan1_dc_bypass));
    c_route_short: cover property ($rose(chan1_route.shorted));
    c_read_wait: cover property (!hreadyout ##1 hreadyout);

endmodule : accr_regs

/* verification/tb.sv */
// Self-checking bench for the channel calibration and configuration bank.
// Assumes accr_regs is the only AHB-Lite slave, so hready is its hreadyout.
`timescale 1ns/100ps
module tb;
    // ------------------------------------------------------------------
    // Signals and reference model state
    // ------------------------------------------------------------------
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd_seen, exp_rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [23:0] chan0_offset, chan0_gain, chan1_offset;
    logic [23:0] e_c0o, e_c0g, e_c1o;
    logic [9:0] chan1_delay_cycles;
    accr_pkg::accr_route_t chan1_route;
    logic chan1_dc_bypass;
    logic [3:0] chan1_dc_setting;
    logic [15:0] mdl [64];
    logic [31:0] r;
    logic [5:0] idx;
    int errors, n_compared, seed;

    // Single slave: its ready is the bus ready
    assign hready = hreadyout;

    accr_regs dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .chan0_offset(chan0_offset),
        .chan0_gain(chan0_gain), .chan1_offset(chan1_offset),
        .chan1_delay_cycles(chan1_delay_cycles), .chan1_route(chan1_route),
        .chan1_dc_bypass(chan1_dc_bypass),
        .chan1_dc_setting(chan1_dc_setting)
    );

    // 40 MHz clock
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    // Watchdog against a hung bus
    initial begin
        #(25 * 100000);
        errors++;
        $display("[FAIL] watchdog expected done seen running");
        tally_and_finish();
    end

    // ------------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------------
    task automatic tally_and_finish();
        $display("Compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] expv);
        n_compared++;
        if (seen !== expv) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, expv, seen);
        end
    endtask : check

    // ------------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------------
    // Writable bits of each index; unmapped places hold nothing
    function automatic logic [15:0] mask(input logic [5:0] i);
        case (i)
            accr_pkg::IDX_GLOBAL_DC: return 16'h000f;
            accr_pkg::IDX_C0_OFS_HI, accr_pkg::IDX_C0_GAIN_HI,
            accr_pkg::IDX_C1_OFS_HI: return 16'hffff;
            accr_pkg::IDX_C0_OFS_LO, accr_pkg::IDX_C0_GAIN_LO,
            accr_pkg::IDX_C1_OFS_LO: return 16'hff00;
            accr_pkg::IDX_C1_CFG: return 16'hffc7;
            default: return 16'h0000;
        endcase
    endfunction : mask

    function automatic logic [23:0] pair(input logic [5:0] h, l);
        return {mdl[h], mdl[l][15:8]};
    endfunction : pair

    function automatic logic [31:0] ad(input logic [5:0] i);
        return {24'h0, i, 2'b00};
    endfunction : ad

    task automatic model_reset();
        foreach (mdl[k]) mdl[k] = 16'h0000;
        mdl[accr_pkg::IDX_C0_GAIN_HI] = 16'h8000;
        e_c0o = 24'h0;
        e_c0g = 24'h800000;
        e_c1o = 24'h0;
    endtask : model_reset

    // Applied value only moves when the low half lands
    task automatic model_wr(input logic [5:0] i, input logic [15:0] d);
        mdl[i] = d & mask(i);
        if (i == accr_pkg::IDX_C0_OFS_LO) begin
            e_c0o = pair(accr_pkg::IDX_C0_OFS_HI, i);
        end
        if (i == accr_pkg::IDX_C0_GAIN_LO) begin
            e_c0g = pair(accr_pkg::IDX_C0_GAIN_HI, i);
        end
        if (i == accr_pkg::IDX_C1_OFS_LO) begin
            e_c1o = pair(accr_pkg::IDX_C1_OFS_HI, i);
        end
    endtask : model_wr

    // ------------------------------------------------------------------
    // Bus master
    // ------------------------------------------------------------------
    // Ready and read data are sampled half a cycle early, where settled
    task automatic wait_ready();
        int n;
        logic rdy;
        n = 0;
        do begin
            @(negedge hclk);
            rdy = hreadyout;
            rd_seen = hrdata;
            @(posedge hclk);
            n++;
        end while (rdy !== 1'b1 && n < 64);
        if (rdy !== 1'b1) begin
            errors++;
            $display("[FAIL] hreadyout expected 1 seen %b", rdy);
            tally_and_finish();
        end
    endtask : wait_ready

    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [2:0] sz, input logic [31:0] d);
        logic ok;
        ok = sz == accr_pkg::HSIZE_WORD && a[1:0] == 2'h0 && a[31:8] == 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= sz;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        check("hresp", {31'h0, hresp}, 32'h0);
        exp_rd = ok ? {16'h0, mdl[a[7:2]]} : 32'h0;
        if (wr && ok) begin
            model_wr(a[7:2], d[15:0]);
        end
    endtask : bus

    // Outputs settle two edges after a write; steering one edge later
    task automatic check_outs();
        logic [15:0] c;
        c = mdl[accr_pkg::IDX_C1_CFG];
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        check("chan0_offset", {8'h0, chan0_offset}, {8'h0, e_c0o});
        check("chan0_gain", {8'h0, chan0_gain}, {8'h0, e_c0g});
        check("chan1_offset", {8'h0, chan1_offset}, {8'h0, e_c1o});
        check("delay", {22'h0, chan1_delay_cycles}, {22'h0, c[15:6]});
        check("route", {28'h0, chan1_route}, 32'h8 >> c[1:0]);
        check("bypass", {31'h0, chan1_dc_bypass}, {31'h0, c[2]});
        if (c[2] == 1'b0) begin
            check("dc_setting", {28'h0, chan1_dc_setting},
                  {28'h0, mdl[accr_pkg::IDX_GLOBAL_DC][3:0]});
        end
        @(posedge hclk);
    endtask : check_outs

    task automatic read_all();
        for (int i = 0; i < 20; i++) begin
            bus(1'b0, ad(i[5:0]), accr_pkg::HSIZE_WORD, 32'h0);
            check("reset read", rd_seen, exp_rd);
        end
        check_outs();
    endtask : read_all

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = accr_pkg::HSIZE_WORD;
        hwdata = 32'h0;
        errors = 0;
        n_compared = 0;
        seed = 89313;
        model_reset();
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        read_all();
        // Gain high alone only stages; the low write applies the pair
        bus(1'b1, ad(accr_pkg::IDX_C0_GAIN_HI), 3'h2, 32'h0000_ffff);
        check_outs();
        bus(1'b1, ad(accr_pkg::IDX_C0_GAIN_LO), 3'h2, 32'hffff_ffff);
        check_outs();
        // Every input route, DC bypass on and off, reserved bits set
        bus(1'b1, ad(accr_pkg::IDX_GLOBAL_DC), 3'h2, 32'hffff_fff5);
        for (int k = 0; k < 8; k++) begin
            r = ($random(seed) & 32'hffff_ffc0) | 32'h38 | k;
            bus(1'b1, ad(accr_pkg::IDX_C1_CFG), 3'h2, r);
            bus(1'b0, ad(accr_pkg::IDX_C1_CFG), 3'h2, 32'h0);
            check("cfg read", rd_seen, exp_rd);
            check_outs();
        end
        // Random traffic, each write read back straight after
        for (int k = 0; k < 60; k++) begin
            r = $random(seed);
            idx = r[3] ? r[9:4] : 6'h0a + {3'h0, r[2:0]};
            bus(1'b1, ad(idx), 3'h2, $random(seed));
            bus(1'b0, ad(idx), 3'h2, 32'h0);
            check("rand read", rd_seen, exp_rd);
            check_outs();
        end
        // Refused: half word, misaligned, above the map
        bus(1'b1, ad(accr_pkg::IDX_C1_OFS_HI), 3'h1, 32'h5a5a);
        bus(1'b1, ad(accr_pkg::IDX_C1_OFS_HI) | 32'h2, 3'h2, 32'h5a5a);
        bus(1'b1, ad(accr_pkg::IDX_C1_OFS_HI) | 32'h100, 3'h2, 32'h5a5a);
        bus(1'b0, ad(accr_pkg::IDX_C1_OFS_HI), 3'h1, 32'h0);
        check("half read", rd_seen, exp_rd);
        bus(1'b0, ad(accr_pkg::IDX_C1_OFS_HI), 3'h2, 32'h0);
        check("kept read", rd_seen, exp_rd);
        // Reset again in mid-run
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        model_reset();
        @(posedge hclk);
        read_all();
        tally_and_finish();
    end
endmodule : tb
